// ===== hw/svm_ctrl.v
/*
  Supply voltage monitor control: noise filters, limit flags, error pin,
  monitor reset request, delay monitor flag and the register port.
  Assumes asynchronous comparator, delay and oscillator inputs, and an option
  word that is stable while reset is asserted and just after its release.
*/
`timescale 1ns/100ps
`default_nettype none
`include "svm_defines.vh"

module svm_filt (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire tick_in,
  input wire raw_in,
  input wire en_in,
  input wire [1:0] width_in,
  output wire level_out
);
  reg out_ff;
  reg [4:0] cnt_ff;
  reg [4:0] width;

  always @* begin
    case (width_in)
      2'h0: width = `SVM_WIDTH_00;
      2'h1: width = `SVM_WIDTH_01;
      2'h2: width = `SVM_WIDTH_10;
      default: width = `SVM_WIDTH_11;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_ff <= 1'b0;
      cnt_ff <= 5'h00;
    end else if (ce_in) begin
      if (raw_in == out_ff) begin
        cnt_ff <= 5'h00;
      end else if (tick_in) begin
        if (cnt_ff + 5'h01 >= width) begin
          out_ff <= raw_in;
          cnt_ff <= 5'h00;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

  // A disabled filter passes the synchronised comparator level straight on.
  assign level_out = en_in ? out_ff : raw_in;
endmodule

module svm_ctrl (
  // Clock, reset and clock enable
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire CE_IN,
  // Register port
  input wire [`SVM_ADDR_W-1:0] ADDR_IN,
  input wire [31:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output wire [31:0] RDATA_OUT,
  // Option word, stable around reset release
  input wire [31:0] OPTION_WORD_IN,
  // Asynchronous analog and oscillator inputs, order core, main, I/O
  input wire [2:0] CMP_ABOVE_IN,
  input wire [2:0] CMP_BELOW_IN,
  input wire DELAY_SHORT_IN,
  input wire HV_OSC_CLOCK_IN,
  // Error reporting
  output wire SUPPLY_ERROR_OUT,
  output wire MON_RESET_REQ_OUT
);
  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n = rst_s2_ff;

  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else if (CE_IN) begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // Two-stage synchronisers for every asynchronous input.
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg osc_prev_ff;

  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      osc_prev_ff <= 1'b0;
    end else if (CE_IN) begin
      sync1_ff <= {HV_OSC_CLOCK_IN, DELAY_SHORT_IN, CMP_BELOW_IN, CMP_ABOVE_IN};
      sync2_ff <= sync1_ff;
      osc_prev_ff <= sync2_ff[7];
    end
  end

  wire [2:0] above = sync2_ff[2:0];
  wire [2:0] below = sync2_ff[5:3];
  wire delay_short = sync2_ff[6];
  wire osc_edge = sync2_ff[7] & ~osc_prev_ff;

  // The oscillator must run below half the system clock to be seen edge by edge.
  reg [7:0] prescale_ff;

  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      prescale_ff <= 8'h00;
    end else if (CE_IN && osc_edge) begin
      prescale_ff <= prescale_ff + 8'h01;
    end
  end

  reg [31:0] option_ff;
  reg load_pend_ff;
  reg key_open_ff;
  reg [4:0] fcfg_ff [0:2];
  reg [5:0] det_ff [0:2];
  reg [5:0] flags_ff;
  reg dly_flag_ff;
  reg err_out_ff;
  reg rst_req_ff;
  reg [31:0] rdata_ff;

  // Filter configuration fields: width [4:3], clock select [2:1], enable [0].
  reg [2:0] tick;
  wire [5:0] level;
  integer r;

  always @* begin
    tick = 3'h0;
    for (r = 0; r < 3; r = r + 1) begin
      case (fcfg_ff[r][2:1])
        2'h0: tick[r] = osc_edge && ((prescale_ff & `SVM_DIV_256) == `SVM_DIV_256);
        2'h1: tick[r] = osc_edge && ((prescale_ff & `SVM_DIV_128) == `SVM_DIV_128);
        2'h2: tick[r] = osc_edge && ((prescale_ff & `SVM_DIV_64) == `SVM_DIV_64);
        default: tick[r] = osc_edge && ((prescale_ff & `SVM_DIV_32) == `SVM_DIV_32);
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : rail
      svm_filt u_hi (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .tick_in(tick[g]),
        .raw_in(above[g]),
        .en_in(fcfg_ff[g][0]),
        .width_in(fcfg_ff[g][4:3]),
        .level_out(level[2*g])
      );
      svm_filt u_lo (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .tick_in(tick[g]),
        .raw_in(below[g]),
        .en_in(fcfg_ff[g][0]),
        .width_in(fcfg_ff[g][4:3]),
        .level_out(level[2*g+1])
      );
    end
  endgenerate

  // Flag bits: core upper, core lower, main upper, main lower, I/O upper, I/O lower.
  wire [5:0] err_now;
  assign err_now[0] = level[0] & det_ff[0][`SVM_DET_UPPER_EN];
  assign err_now[1] = (level[1] & det_ff[0][`SVM_DET_LOWER_EN]) | delay_short;
  assign err_now[2] = level[2] & det_ff[1][`SVM_DET_UPPER_EN];
  assign err_now[3] = level[3];
  assign err_now[4] = level[4] & det_ff[2][`SVM_DET_UPPER_EN];
  assign err_now[5] = level[5];

  wire reset_now = err_now[3] | err_now[5] |
    (err_now[0] & det_ff[0][`SVM_DET_UPPER_RST]) |
    (err_now[1] & det_ff[0][`SVM_DET_LOWER_RST]) |
    (err_now[2] & det_ff[1][`SVM_DET_UPPER_RST]) |
    (err_now[4] & det_ff[2][`SVM_DET_UPPER_RST]);

  wire wr_key = WR_IN && (ADDR_IN == `SVM_OFF_KEY);
  wire wr_prot = WR_IN && key_open_ff;
  wire wr_clr = WR_IN && (ADDR_IN == `SVM_OFF_FLAG_CLR);

  // Thresholds live in the analog comparators; no register reaches them.
  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      option_ff <= 32'h00000000;
      load_pend_ff <= 1'b1;
      key_open_ff <= 1'b0;
      fcfg_ff[0] <= `SVM_FCFG_RESET;
      fcfg_ff[1] <= `SVM_FCFG_RESET;
      fcfg_ff[2] <= `SVM_FCFG_RESET;
      det_ff[0] <= `SVM_DET_RESET;
      det_ff[1] <= `SVM_DET_RESET;
      det_ff[2] <= `SVM_DET_RESET;
      flags_ff <= 6'h00;
      dly_flag_ff <= 1'b0;
      err_out_ff <= 1'b0;
      rst_req_ff <= 1'b0;
    end else if (CE_IN) begin
      if (load_pend_ff) begin
        load_pend_ff <= 1'b0;
        option_ff <= OPTION_WORD_IN;
        fcfg_ff[0] <= OPTION_WORD_IN[`SVM_OPT_CORE_CFG_HI:`SVM_OPT_CORE_CFG_LO];
        fcfg_ff[1] <= OPTION_WORD_IN[`SVM_OPT_MAIN_CFG_HI:`SVM_OPT_MAIN_CFG_LO];
        fcfg_ff[2] <= OPTION_WORD_IN[`SVM_OPT_IO_CFG_HI:`SVM_OPT_IO_CFG_LO];
        det_ff[0][`SVM_DET_LOWER_EN] <= OPTION_WORD_IN[`SVM_OPT_CORE_LOWER];
        det_ff[0][`SVM_DET_UPPER_EN] <= OPTION_WORD_IN[`SVM_OPT_CORE_UPPER];
        det_ff[0][`SVM_DET_OUT_EN] <= OPTION_WORD_IN[`SVM_OPT_CORE_RSVD];
        det_ff[1][`SVM_DET_UPPER_EN] <= OPTION_WORD_IN[`SVM_OPT_MAIN_HIGH];
        det_ff[2][`SVM_DET_UPPER_EN] <= OPTION_WORD_IN[`SVM_OPT_IO_HIGH];
      end else if (wr_key) begin
        if (WDATA_IN == `SVM_KEY_OPEN) begin
          key_open_ff <= 1'b1;
        end else if (WDATA_IN == `SVM_KEY_SHUT) begin
          key_open_ff <= 1'b0;
        end
      end else if (wr_prot) begin
        if (ADDR_IN == `SVM_OFF_CORE_FCFG) begin
          fcfg_ff[0] <= WDATA_IN[4:0];
        end else if (ADDR_IN == `SVM_OFF_MAIN_FCFG) begin
          fcfg_ff[1] <= WDATA_IN[4:0];
        end else if (ADDR_IN == `SVM_OFF_IO_FCFG) begin
          fcfg_ff[2] <= WDATA_IN[4:0];
        end else if (ADDR_IN == `SVM_OFF_CORE_DET) begin
          det_ff[0] <= WDATA_IN[5:0];
        end else if (ADDR_IN == `SVM_OFF_MAIN_DET) begin
          det_ff[1] <= WDATA_IN[5:0];
        end else if (ADDR_IN == `SVM_OFF_IO_DET) begin
          det_ff[2] <= WDATA_IN[5:0];
        end
      end
      // A new error in the clearing cycle keeps its flag set.
      flags_ff <= (flags_ff & ~(wr_clr ? WDATA_IN[5:0] : 6'h00)) | err_now;
      dly_flag_ff <= (dly_flag_ff & ~(wr_clr & WDATA_IN[6])) | delay_short;
      err_out_ff <= (|err_now) & det_ff[0][`SVM_DET_OUT_EN];
      rst_req_ff <= reset_now;
    end
  end

  always @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (CE_IN) begin
      if (!RD_IN) begin
        rdata_ff <= 32'h00000000;
      end else if (ADDR_IN == `SVM_OFF_OPTION) begin
        rdata_ff <= option_ff;
      end else if (ADDR_IN == `SVM_OFF_KEY) begin
        rdata_ff <= {31'h00000000, key_open_ff};
      end else if (ADDR_IN == `SVM_OFF_CORE_FCFG) begin
        rdata_ff <= {27'h0000000, fcfg_ff[0]};
      end else if (ADDR_IN == `SVM_OFF_MAIN_FCFG) begin
        rdata_ff <= {27'h0000000, fcfg_ff[1]};
      end else if (ADDR_IN == `SVM_OFF_IO_FCFG) begin
        rdata_ff <= {27'h0000000, fcfg_ff[2]};
      end else if (ADDR_IN == `SVM_OFF_CORE_DET) begin
        rdata_ff <= {26'h0000000, det_ff[0]};
      end else if (ADDR_IN == `SVM_OFF_MAIN_DET) begin
        rdata_ff <= {26'h0000000, det_ff[1]};
      end else if (ADDR_IN == `SVM_OFF_IO_DET) begin
        rdata_ff <= {26'h0000000, det_ff[2]};
      end else if (ADDR_IN == `SVM_OFF_FLAGS) begin
        rdata_ff <= {25'h0000000, dly_flag_ff, flags_ff};
      end else if (ADDR_IN == `SVM_OFF_DLY_FLAGS) begin
        rdata_ff <= {31'h00000000, dly_flag_ff};
      end else if (ADDR_IN == `SVM_OFF_STATUS) begin
        rdata_ff <= {24'h000000, rst_req_ff, err_out_ff, err_now};
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end
  end

  assign RDATA_OUT = rdata_ff;
  assign SUPPLY_ERROR_OUT = err_out_ff;
  assign MON_RESET_REQ_OUT = rst_req_ff;
endmodule

`default_nettype wire

// ===== hw/svm_defines.vh
/*
  Shared constants of the supply voltage monitor control: register offsets,
  field positions, reset values and noise filter counts.
  Assumes byte offsets on an 8-bit register address.
*/
`ifndef SVM_DEFINES_VH
`define SVM_DEFINES_VH

`define SVM_ADDR_W 8
`define SVM_OFF_OPTION 8'h00
`define SVM_OFF_KEY 8'h04
`define SVM_OFF_CORE_FCFG 8'h08
`define SVM_OFF_MAIN_FCFG 8'h0C
`define SVM_OFF_IO_FCFG 8'h10
`define SVM_OFF_CORE_DET 8'h14
`define SVM_OFF_MAIN_DET 8'h18
`define SVM_OFF_IO_DET 8'h1C
`define SVM_OFF_FLAGS 8'h20
`define SVM_OFF_FLAG_CLR 8'h24
`define SVM_OFF_DLY_FLAGS 8'h28
`define SVM_OFF_STATUS 8'h2C

`define SVM_KEY_OPEN 32'hA5A5A501
`define SVM_KEY_SHUT 32'hA5A5A500

`define SVM_OPT_CORE_CFG_HI 31
`define SVM_OPT_CORE_CFG_LO 27
`define SVM_OPT_CORE_RSVD 26
`define SVM_OPT_CORE_UPPER 25
`define SVM_OPT_CORE_LOWER 24
`define SVM_OPT_MAIN_CFG_HI 23
`define SVM_OPT_MAIN_CFG_LO 19
`define SVM_OPT_MAIN_HIGH 17
`define SVM_OPT_IO_CFG_HI 15
`define SVM_OPT_IO_CFG_LO 11
`define SVM_OPT_IO_HIGH 9

`define SVM_DET_LOWER_EN 0
`define SVM_DET_UPPER_EN 1
`define SVM_DET_OUT_EN 3
`define SVM_DET_UPPER_RST 4
`define SVM_DET_LOWER_RST 5

`define SVM_FCFG_RESET 5'h00
`define SVM_DET_RESET 6'h00

`define SVM_WIDTH_00 5'h14
`define SVM_WIDTH_01 5'h0D
`define SVM_WIDTH_10 5'h08
`define SVM_WIDTH_11 5'h03

`define SVM_DIV_256 8'hFF
`define SVM_DIV_128 8'h7F
`define SVM_DIV_64 8'h3F
`define SVM_DIV_32 8'h1F

`endif

// ===== tb/svm_ctrl_props.sv
/*
  Port checker of the supply voltage monitor control.
  Assumes the clock enable is low only while no register access is made.
*/
`timescale 1ns/100ps
`default_nettype none
`include "svm_defines.vh"

module svm_ctrl_props (
  // Clock, reset and register port
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire [`SVM_ADDR_W-1:0] ADDR_IN,
  input wire [31:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire [31:0] RDATA_OUT,
  // Monitor side
  input wire [31:0] OPTION_WORD_IN,
  input wire [2:0] CMP_ABOVE_IN,
  input wire [2:0] CMP_BELOW_IN,
  input wire DELAY_SHORT_IN,
  input wire SUPPLY_ERROR_OUT,
  input wire MON_RESET_REQ_OUT
);
  wire any_err = |{CMP_ABOVE_IN, CMP_BELOW_IN, DELAY_SHORT_IN};
  wire key_wr = WR_IN && ADDR_IN == `SVM_OFF_KEY;
  wire key_rd = RD_IN && ADDR_IN == `SVM_OFF_KEY;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
    else $error("read data outside read slot");
  opt_read_a: assert property ($past(RD_IN && ADDR_IN == `SVM_OFF_OPTION) |->
    RDATA_OUT == $past(OPTION_WORD_IN)) else $error("option word readback wrong");
  unmapped_read_a: assert property ($past(RD_IN && ADDR_IN > `SVM_OFF_STATUS) |-> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  flag_width_a: assert property ($past(RD_IN && ADDR_IN == `SVM_OFF_FLAGS) |->
    RDATA_OUT[31:7] == 25'h0) else $error("flag register upper bits set");
  key_open_a: assert property ($past(key_wr && WDATA_IN == `SVM_KEY_OPEN, 2) && $past(key_rd) |->
    RDATA_OUT[0]) else $error("key did not open");
  key_shut_a: assert property ($past(key_wr && WDATA_IN == `SVM_KEY_SHUT, 2) && $past(key_rd) |->
    !RDATA_OUT[0]) else $error("key did not shut");
  reset_cause_a: assert property ($rose(MON_RESET_REQ_OUT) |-> $past(any_err, 3))
    else $error("reset request without error input");
  pin_cause_a: assert property ($rose(SUPPLY_ERROR_OUT) |-> $past(any_err, 3))
    else $error("error pin without error input");
  reset_quiet_a: assert property ($rose(RST_N_IN) |-> (!MON_RESET_REQ_OUT && !SUPPLY_ERROR_OUT) [*2])
    else $error("outputs active at reset release");
endmodule

bind svm_ctrl svm_ctrl_props u_props (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .OPTION_WORD_IN(OPTION_WORD_IN),
  .CMP_ABOVE_IN(CMP_ABOVE_IN), .CMP_BELOW_IN(CMP_BELOW_IN), .DELAY_SHORT_IN(DELAY_SHORT_IN),
  .SUPPLY_ERROR_OUT(SUPPLY_ERROR_OUT), .MON_RESET_REQ_OUT(MON_RESET_REQ_OUT));
`default_nettype wire

// ===== tb/svm_rail_model.sv
/*
  Far side of the monitor: comparators, delay sensor, oscillator, option word.
  Assumes the bench sets the rail levels it wants to see.
*/
`timescale 1ns/100ps
`default_nettype none

module svm_rail_model (
  // Levels asked for by the bench
  input wire logic [2:0] above_in,
  input wire logic [2:0] below_in,
  input wire logic dly_in,
  // Analog side
  output logic [2:0] above_out,
  output logic [2:0] below_out,
  output logic dly_out,
  output logic osc_out,
  output logic [31:0] option_out
);
  // Reserved bits are ones; core filter off with width 11 and clock 11.
  assign option_out = 32'hF70507FF;
  assign above_out = above_in;
  assign below_out = below_in;
  assign dly_out = dly_in;
  // A 400 ns period keeps the oscillator slow enough for the two-flop sampler.
  initial begin
    osc_out = 1'b0;
    forever #200 osc_out = ~osc_out;
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench of the supply voltage monitor control.
  Assumes the rail model as far side and a 10 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "svm_defines.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module tb_top;
  logic clk, rst_n, wr, rd, dly, dly_w, osc, err, req, ce;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, opt, d;
  logic [2:0] ab, bl, ab_w, bl_w;
  int checks, error_cnt;
  svm_rail_model u_model (.above_in(ab), .below_in(bl), .dly_in(dly), .above_out(ab_w),
    .below_out(bl_w), .dly_out(dly_w), .osc_out(osc), .option_out(opt));
  svm_ctrl DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .OPTION_WORD_IN(opt), .CMP_ABOVE_IN(ab_w),
    .CMP_BELOW_IN(bl_w), .DELAY_SHORT_IN(dly_w), .HV_OSC_CLOCK_IN(osc), .SUPPLY_ERROR_OUT(err),
    .MON_RESET_REQ_OUT(req));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Key write and readback back to back, so the read sees the new state.
  task automatic key_rw(input logic [31:0] v);
    @(posedge clk);
    addr <= `SVM_OFF_KEY;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_in(input logic [2:0] a, input logic [2:0] b, input logic y, input int n);
    @(posedge clk);
    ab <= a;
    bl <= b;
    dly <= y;
    cyc(n);
  endtask
  task automatic t_reset;
    rd_reg(`SVM_OFF_OPTION);
    `CHK("option", 32'hF70507FF, d)
    rd_reg(`SVM_OFF_CORE_DET);
    `CHK("core det", 32'h0000000B, d)
    rd_reg(`SVM_OFF_IO_DET);
    `CHK("io det", 32'h00000002, d)
    rd_reg(`SVM_OFF_CORE_FCFG);
    `CHK("core fcfg", 32'h0000001E, d)
    rd_reg(8'h30);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
  endtask
  task automatic t_key;
    wr_reg(`SVM_OFF_MAIN_DET, 32'h12);
    rd_reg(`SVM_OFF_MAIN_DET);
    `CHK("locked", 32'h0, d)
    key_rw(`SVM_KEY_OPEN);
    `CHK("key open", 32'h1, d[0])
    wr_reg(`SVM_OFF_MAIN_DET, 32'h12);
    key_rw(`SVM_KEY_SHUT);
    `CHK("key shut", 32'h0, d[0])
    wr_reg(`SVM_OFF_MAIN_DET, 32'h0);
    rd_reg(`SVM_OFF_MAIN_DET);
    `CHK("shut write", 32'h12, d)
    key_rw(`SVM_KEY_OPEN);
    $display("test key done");
  endtask
  task automatic t_main;
    set_in(3'b000, 3'b010, 1'b0, 3);
    `CHK("low reset", 1'b1, req)
    `CHK("low pin", 1'b1, err)
    set_in(3'b010, 3'b000, 1'b0, 4);
    `CHK("high reset", 1'b1, req)
    set_in(3'b000, 3'b000, 1'b0, 4);
    `CHK("req idle", 1'b0, req)
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("sticky", 32'h0000000C, d)
    wr_reg(`SVM_OFF_FLAG_CLR, 32'h0C);
    wr_reg(`SVM_OFF_MAIN_DET, 32'h02);
    set_in(3'b010, 3'b000, 1'b0, 4);
    `CHK("no reset", 1'b0, req)
    `CHK("pin", 1'b1, err)
    wr_reg(`SVM_OFF_MAIN_DET, 32'h0);
    wr_reg(`SVM_OFF_FLAG_CLR, 32'h04);
    cyc(4);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("high off", 32'h0, d)
    set_in(3'b000, 3'b000, 1'b1, 4);
    `CHK("delay reset", 1'b0, req)
    set_in(3'b000, 3'b000, 1'b0, 3);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("delay flags", 32'h00000042, d)
    wr_reg(`SVM_OFF_FLAG_CLR, 32'h42);
    rd_reg(`SVM_OFF_DLY_FLAGS);
    `CHK("delay clr", 32'h0, d)
    $display("test main done");
  endtask
  // Three ticks of one per 32 oscillator edges, each edge four clocks.
  task automatic t_filter;
    wr_reg(`SVM_OFF_CORE_FCFG, 32'h1F);
    set_in(3'b001, 3'b000, 1'b0, 60);
    set_in(3'b000, 3'b000, 1'b0, 600);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("glitch", 32'h0, d)
    set_in(3'b001, 3'b000, 1'b0, 100);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("early", 32'h0, d)
    cyc(400);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("filtered", 32'h1, d)
    $display("test filter done");
  endtask
  // Each case uses a rail whose filter is at rest and leaves that filter disabled afterwards.
  task automatic filt_case(input logic [7:0] fa, input logic [4:0] cfg, input logic [2:0] b, input int n,
      input int p, input int i, input logic r);
    wr_reg(fa, {27'h0000000, cfg});
    set_in(3'b000, b, 1'b0, (n - 1) * p - 100);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("filter early", 1'b0, d[i])
    `CHK("early reset", 1'b0, req)
    cyc(p + 200);
    rd_reg(`SVM_OFF_FLAGS);
    `CHK("filter late", 1'b1, d[i])
    `CHK("late reset", r, req)
    wr_reg(fa, {27'h0000000, cfg & 5'h1E});
  endtask
  // One oscillator edge every four clocks, so a tick period is four clocks times the divider.
  task automatic t_filter_modes;
    filt_case(`SVM_OFF_IO_FCFG, 5'h05, 3'b100, `SVM_WIDTH_00, 4 * 64, 5, 1'b1);
    filt_case(`SVM_OFF_MAIN_FCFG, 5'h0B, 3'b010, `SVM_WIDTH_01, 4 * 128, 3, 1'b1);
    filt_case(`SVM_OFF_CORE_FCFG, 5'h11, 3'b001, `SVM_WIDTH_10, 4 * 256, 1, 1'b0);
    $display("test filter modes done");
  endtask
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    bl <= 3'b010;
    cyc(10);
    `CHK("frozen", 1'b0, req)
    @(posedge clk);
    ce <= 1'b1;
    cyc(3);
    `CHK("resumed", 1'b1, req)
    set_in(3'b000, 3'b000, 1'b0, 3);
    $display("test ce done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The tests take about 22,000 clocks; the limit leaves a margin above that.
  initial begin
    #3000000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {rst_n, wr, rd, dly, ab, bl, addr, wdata} = '0;
    ce = 1'b1;
    checks = 0;
    error_cnt = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_key();
    t_main();
    t_filter();
    t_filter_modes();
    t_ce();
    stop_test();
  end
endmodule
`default_nettype wire
